// ===== core/fpec_regs.vh
// constants for the flash program and erase sequencer
`ifndef FPEC_REGS_VH
`define FPEC_REGS_VH

`define FPEC_OFF_KEY      12'h0000
`define FPEC_OFF_CTRL     12'h0004
`define FPEC_OFF_PFE      12'h0008
`define FPEC_OFF_SCALE    12'h000C
`define FPEC_OFF_STAT     12'h0010

`define FPEC_CTRL_WE_BIT  0
`define FPEC_CTRL_EE_BIT  1
`define FPEC_PFE_BWS_BIT  0
`define FPEC_SCALE_RT_BIT 0
`define FPEC_STAT_BUSY_BIT 2
`define FPEC_STAT_HOLD_BIT 3

`define FPEC_KEY_FIRST    8'hA5
`define FPEC_KEY_SECOND   8'hF1
`define FPEC_ERASED       8'hFF

`define FPEC_KEY_LOCKED   2'h0
`define FPEC_KEY_HALF     2'h1
`define FPEC_KEY_OPEN     2'h2
`define FPEC_KEY_DEAD     2'h3

`define FPEC_FLASH_BYTES  65536
`define FPEC_RESV_BASE    16'hFC00
`define FPEC_PAGE_W       9

`define FPEC_CLK_KHZ        20000
`define FPEC_ERASE_TIME_US  15000
`define FPEC_WRITE_TIME_NS  55000
`define FPEC_ERASE_CYCLES   (`FPEC_ERASE_TIME_US * `FPEC_CLK_KHZ / 1000)
`define FPEC_WRITE_CYCLES   (`FPEC_WRITE_TIME_NS * `FPEC_CLK_KHZ / 1000000)
`define FPEC_TMR_W          19

`define FPEC_DATA_ZERO    32'h0000_0000

`endif

// ===== core/fpec_op_timer.v
// down counter timing one flash operation, pulses done at the end
`include "fpec_regs.vh"

module fpec_op_timer (
   ref_clk,
   rst,
   load,
   count,
   done
);
   input  wire                   ref_clk;
   input  wire                   rst;
   input  wire                   load;
   input  wire [`FPEC_TMR_W-1:0] count;
   output wire                   done;

   reg [`FPEC_TMR_W-1:0] cnt_reg;

   // done is high in the count-th cycle after load
   assign done = (cnt_reg == {{(`FPEC_TMR_W-1){1'b0}}, 1'b1});

   always @(posedge ref_clk) begin
      if (rst) begin
         cnt_reg <= {`FPEC_TMR_W{1'b0}};
      end else if (load) begin
         cnt_reg <= count;
      end else if (cnt_reg != {`FPEC_TMR_W{1'b0}}) begin
         cnt_reg <= cnt_reg - {{(`FPEC_TMR_W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// ===== core/fpec_top.v
// flash program and erase sequencer with apb registers and core store port
`include "fpec_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module fpec_top #(
   parameter [`FPEC_TMR_W-1:0] ERASE_CYCLES = `FPEC_ERASE_CYCLES
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        core_xwr,
   input  wire        core_xrd,
   input  wire [15:0] core_xaddr,
   input  wire [7:0]  core_xdata,
   output wire        core_stall,
   output wire        external_data_ram_we,
   output wire        external_data_ram_re,
   output wire [15:0] external_data_ram_addr,
   output wire [7:0]  external_data_ram_wdata,
   input  wire [15:0] code_rd_addr,
   output wire [7:0]  code_rd_data,
   output wire        flash_read_timing_select,
   output wire        flash_lockout
);
   localparam integer           WRITE_INT = `FPEC_WRITE_CYCLES;
   localparam [`FPEC_TMR_W-1:0] WRITE_CNT = WRITE_INT[`FPEC_TMR_W-1:0];
   localparam [`FPEC_TMR_W-1:0] ERASE_CNT = ERASE_CYCLES;

   localparam [1:0] SEQ_IDLE  = 2'h0;
   localparam [1:0] SEQ_WRITE = 2'h1;
   localparam [1:0] SEQ_ERASE = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   reg [7:0] flash_mem [0:`FPEC_FLASH_BYTES-1];
   reg        wen_reg;
   reg        een_reg;
   reg        bws_reg;
   reg        flash_read_timing_select_reg;
   reg [1:0]  key_reg;
   reg [1:0]  key_next;
   reg [31:0] prdata_reg;
   reg [31:0] rd_next;
   reg [1:0]  seq_reg;
   reg        first_reg;
   reg        pair_reg;
   reg [15:0] op_addr_reg;
   reg [7:0]  op_data_reg;
   reg [7:0]  op_data2_reg;
   reg [`FPEC_PAGE_W-1:0] erase_ptr_reg;
   reg        erase_full_reg;
   reg        hold_vld_reg;
   reg [14:0] hold_addr_reg;
   reg [7:0]  hold_data_reg;
   reg        external_data_ram_we_reg;
   reg        external_data_ram_re_reg;
   reg [15:0] external_data_ram_addr_reg;
   reg [7:0]  external_data_ram_wdata_reg;
   reg [7:0]  code_rd_data_reg;
   reg        mem_we;
   reg        mem_erase;
   reg [15:0] mem_wa;

   ////////////////////////////////////////////////////////////////////////////
   wire apb_setup = psel & ~penable;
   wire apb_wr    = psel & penable & pwrite;
   wire sel_key   = (paddr == `FPEC_OFF_KEY);
   wire sel_ctrl  = (paddr == `FPEC_OFF_CTRL);
   wire sel_pfe   = (paddr == `FPEC_OFF_PFE);
   wire sel_scale = (paddr == `FPEC_OFF_SCALE);
   wire sel_stat  = (paddr == `FPEC_OFF_STAT);
   wire addr_hit  = sel_key | sel_ctrl | sel_pfe | sel_scale | sel_stat;
   // no wait states; unmapped words answer with an error and read zero
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_hit;
   assign prdata  = prdata_reg;
   wire key_wr = apb_wr & sel_key;
   wire busy   = (seq_reg != SEQ_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      if (rst) begin
         wen_reg  <= 1'b0;
         een_reg  <= 1'b0;
         bws_reg  <= 1'b0;
         flash_read_timing_select_reg <= 1'b0;
      end else if (apb_wr) begin
         if (sel_ctrl) begin
            // only software changes the enables
            wen_reg <= pwdata[`FPEC_CTRL_WE_BIT];
            een_reg <= pwdata[`FPEC_CTRL_EE_BIT];
         end else if (sel_pfe) begin
            bws_reg <= pwdata[`FPEC_PFE_BWS_BIT];
         end else if (sel_scale) begin
            flash_read_timing_select_reg <= pwdata[`FPEC_SCALE_RT_BIT];
         end
      end
   end

   assign flash_read_timing_select = flash_read_timing_select_reg;

   always @* begin
      rd_next = `FPEC_DATA_ZERO;
      if (sel_key) begin
         rd_next[1:0] = key_reg;
      end else if (sel_ctrl) begin
         rd_next[`FPEC_CTRL_WE_BIT] = wen_reg;
         rd_next[`FPEC_CTRL_EE_BIT] = een_reg;
      end else if (sel_pfe) begin
         rd_next[`FPEC_PFE_BWS_BIT] = bws_reg;
      end else if (sel_scale) begin
         rd_next[`FPEC_SCALE_RT_BIT] = flash_read_timing_select_reg;
      end else if (sel_stat) begin
         rd_next[1:0] = key_reg;
         rd_next[`FPEC_STAT_BUSY_BIT] = busy;
         rd_next[`FPEC_STAT_HOLD_BIT] = hold_vld_reg;
      end
   end

   // read data is latched in the setup phase so it is a flop in the access phase
   always @(posedge ref_clk) begin
      if (rst) begin
         prdata_reg <= `FPEC_DATA_ZERO;
      end else if (apb_setup) begin
         prdata_reg <= rd_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   wire flash_st = core_xwr & wen_reg & ~busy;
   wire in_resv  = (core_xaddr >= `FPEC_RESV_BASE);
   wire is_open  = (key_reg == `FPEC_KEY_OPEN);
   wire go       = flash_st & is_open & ~key_wr & ~in_resv;
   wire erase_go = go & een_reg;
   wire byte_go  = go & ~een_reg & ~bws_reg;
   wire even_go  = go & ~een_reg & bws_reg & ~core_xaddr[0];
   wire odd_go   = go & ~een_reg & bws_reg & core_xaddr[0];
   wire tmr_load = erase_go | byte_go | odd_go;
   wire tmr_done;

   always @* begin
      key_next = key_reg;
      if (key_wr) begin
         case (key_reg)
            `FPEC_KEY_LOCKED: begin
               if (pwdata[7:0] == `FPEC_KEY_FIRST) begin
                  key_next = `FPEC_KEY_HALF;
               end else begin
                  key_next = `FPEC_KEY_DEAD;
               end
            end
            `FPEC_KEY_HALF: begin
               if (pwdata[7:0] == `FPEC_KEY_SECOND) begin
                  key_next = `FPEC_KEY_OPEN;
               end else begin
                  key_next = `FPEC_KEY_DEAD;
               end
            end
            default: begin
               // an extra key after unlock is out of order
               key_next = `FPEC_KEY_DEAD;
            end
         endcase
      end else if (flash_st && (key_reg != `FPEC_KEY_DEAD)) begin
         if (is_open) begin
            // each store, a block half included, consumes the unlock
            key_next = `FPEC_KEY_LOCKED;
         end else begin
            key_next = `FPEC_KEY_DEAD;
         end
      end
   end

   always @(posedge ref_clk) begin
      if (rst) begin
         key_reg <= `FPEC_KEY_LOCKED;
      end else begin
         key_reg <= key_next;
      end
   end

   assign flash_lockout = (key_reg == `FPEC_KEY_DEAD);

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      if (rst) begin
         hold_vld_reg  <= 1'b0;
         hold_addr_reg <= 15'h0000;
         hold_data_reg <= `FPEC_ERASED;
      end else if (even_go) begin
         hold_vld_reg  <= 1'b1;
         hold_addr_reg <= core_xaddr[15:1];
         hold_data_reg <= core_xdata;
      end else if (odd_go | erase_go | byte_go) begin
         hold_vld_reg <= 1'b0;
      end
   end

   // a lone odd store leaves its even partner untouched
   wire       pair_ok   = hold_vld_reg & (hold_addr_reg == core_xaddr[15:1]);
   wire [7:0] even_byte = pair_ok ? hold_data_reg : `FPEC_ERASED;

   ////////////////////////////////////////////////////////////////////////////
   wire [`FPEC_TMR_W-1:0] tmr_count = erase_go ? ERASE_CNT : WRITE_CNT;
   fpec_op_timer u_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .load    (tmr_load),
      .count   (tmr_count),
      .done    (tmr_done)
   );

   always @(posedge ref_clk) begin
      if (rst) begin
         seq_reg        <= SEQ_IDLE;
         first_reg      <= 1'b0;
         pair_reg       <= 1'b0;
         op_addr_reg    <= 16'h0000;
         op_data_reg    <= `FPEC_ERASED;
         op_data2_reg   <= `FPEC_ERASED;
         erase_ptr_reg  <= {`FPEC_PAGE_W{1'b0}};
         erase_full_reg <= 1'b0;
      end else begin
         case (seq_reg)
            SEQ_IDLE: begin
               if (erase_go) begin
                  seq_reg        <= SEQ_ERASE;
                  op_addr_reg    <= {core_xaddr[15:`FPEC_PAGE_W],
                                     {`FPEC_PAGE_W{1'b0}}};
                  erase_ptr_reg  <= {`FPEC_PAGE_W{1'b0}};
                  erase_full_reg <= 1'b0;
               end else if (byte_go) begin
                  seq_reg     <= SEQ_WRITE;
                  first_reg   <= 1'b1;
                  pair_reg    <= 1'b0;
                  op_addr_reg <= core_xaddr;
                  op_data_reg <= core_xdata;
               end else if (odd_go) begin
                  seq_reg      <= SEQ_WRITE;
                  first_reg    <= 1'b1;
                  pair_reg     <= 1'b1;
                  op_addr_reg  <= {core_xaddr[15:1], 1'b0};
                  op_data_reg  <= even_byte;
                  op_data2_reg <= core_xdata;
               end
            end
            SEQ_WRITE: begin
               first_reg <= 1'b0;
               if (tmr_done) begin
                  seq_reg <= SEQ_IDLE;
               end
            end
            SEQ_ERASE: begin
               // one byte per cycle; the erase time covers the page many times over
               if (!erase_full_reg) begin
                  erase_ptr_reg <= erase_ptr_reg + {{(`FPEC_PAGE_W-1){1'b0}}, 1'b1};
                  if (&erase_ptr_reg) begin
                     erase_full_reg <= 1'b1;
                  end
               end
               if (tmr_done) begin
                  seq_reg <= SEQ_IDLE;
               end
            end
            default: begin
               seq_reg <= SEQ_IDLE;
            end
         endcase
      end
   end

   // stall follows the sequencer, not the store, so the core sees it next cycle
   assign core_stall = busy;

   ////////////////////////////////////////////////////////////////////////////
   always @* begin
      mem_we    = 1'b0;
      mem_erase = 1'b0;
      mem_wa    = op_addr_reg;
      if ((seq_reg == SEQ_WRITE) && first_reg) begin
         mem_we = 1'b1;
      end else if ((seq_reg == SEQ_WRITE) && tmr_done && pair_reg) begin
         mem_we = 1'b1;
         mem_wa = {op_addr_reg[15:1], 1'b1};
      end else if ((seq_reg == SEQ_ERASE) && !erase_full_reg) begin
         mem_we    = 1'b1;
         mem_erase = 1'b1;
         mem_wa    = {op_addr_reg[15:`FPEC_PAGE_W], erase_ptr_reg};
      end
   end

   wire [7:0] mem_wd = first_reg ? op_data_reg : op_data2_reg;

   always @(posedge ref_clk) begin
      if (mem_we) begin
         if (mem_erase) begin
            flash_mem[mem_wa] <= `FPEC_ERASED;
         end else begin
            flash_mem[mem_wa] <= flash_mem[mem_wa] & mem_wd;
         end
      end
   end

   // flash contents are read only through the code port
   always @(posedge ref_clk) begin
      if (rst) begin
         code_rd_data_reg <= `FPEC_ERASED;
      end else begin
         code_rd_data_reg <= flash_mem[code_rd_addr];
      end
   end
   assign code_rd_data = code_rd_data_reg;

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge ref_clk) begin
      if (rst) begin
         external_data_ram_we_reg    <= 1'b0;
         external_data_ram_re_reg    <= 1'b0;
         external_data_ram_addr_reg  <= 16'h0000;
         external_data_ram_wdata_reg <= 8'h00;
      end else begin
         external_data_ram_we_reg <= core_xwr & ~wen_reg & ~busy;
         external_data_ram_re_reg <= core_xrd & ~busy;
         if ((core_xwr | core_xrd) & ~busy) begin
            external_data_ram_addr_reg  <= core_xaddr;
            external_data_ram_wdata_reg <= core_xdata;
         end
      end
   end

   assign external_data_ram_we    = external_data_ram_we_reg;
   assign external_data_ram_re    = external_data_ram_re_reg;
   assign external_data_ram_addr  = external_data_ram_addr_reg;
   assign external_data_ram_wdata = external_data_ram_wdata_reg;

endmodule

// ===== test/fpec_monitor.sv
// port checker for the flash program and erase sequencer
module fpec_monitor #(
   parameter int ERASE_CYCLES = 300000
) (
   input wire        ref_clk,
   input wire        rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire        core_xwr,
   input wire        core_xrd,
   input wire [15:0] core_xaddr,
   input wire [7:0]  core_xdata,
   input wire        core_stall,
   input wire        external_data_ram_we,
   input wire        external_data_ram_re,
   input wire [15:0] external_data_ram_addr,
   input wire [7:0]  external_data_ram_wdata,
   input wire        flash_lockout
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   // counts stall cycles so one counter checks both exact operation lengths
   logic [18:0] stall_cnt;
   always @(posedge ref_clk) begin
      if (rst || !core_stall)
         stall_cnt <= 19'h0_0000;
      else
         stall_cnt <= stall_cnt + 19'h0_0001;
   end
   sequence s_store;
      core_xwr && !core_stall;
   endsequence
   sequence s_dead_store;
      flash_lockout ##0 s_store;
   endsequence
   ////////////////////////////////////////
   lockout_sticky_a: assert property (flash_lockout |=> flash_lockout)
      else $error("lockout dropped");
   lockout_cause_a: assert property ($rose(flash_lockout) |->
      $past(core_xwr || (psel && penable && pwrite && paddr == 12'h000)))
      else $error("lockout without cause");
   dead_store_a: assert property (s_dead_store |=> !core_stall)
      else $error("operation while locked out");
   stall_cause_a: assert property ($rose(core_stall) |-> $past(core_xwr))
      else $error("stall without store");
   stall_len_a: assert property ($fell(core_stall) |->
      stall_cnt == 19'h0_044C || stall_cnt == 19'(ERASE_CYCLES))
      else $error("operation length wrong");
   stall_hold_a: assert property ($rose(core_stall) |-> core_stall[*8])
      else $error("stall too short");
   external_data_ram_store_a: assert property (external_data_ram_we |-> $past(core_xwr) &&
      external_data_ram_wdata == $past(core_xdata) && external_data_ram_addr == $past(core_xaddr))
      else $error("ram store mismatch");
   external_data_ram_read_a: assert property (core_xrd && !core_stall |=> external_data_ram_re)
      else $error("read not sent to ram");
   stall_quiet_a: assert property (core_stall |-> !external_data_ram_we && !external_data_ram_re)
      else $error("ram access while stalled");
endmodule

bind fpec_top fpec_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) mon (
   .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .core_xwr(core_xwr), .core_xrd(core_xrd),
   .core_xaddr(core_xaddr), .core_xdata(core_xdata), .core_stall(core_stall),
   .external_data_ram_we(external_data_ram_we), .external_data_ram_re(external_data_ram_re), .external_data_ram_addr(external_data_ram_addr),
   .external_data_ram_wdata(external_data_ram_wdata), .flash_lockout(flash_lockout));

// ===== test/fpec_core_model.sv
// behavioural core issuing external stores and reads
module fpec_core_model (
   input  wire         ref_clk,
   output logic        core_xwr,
   output logic        core_xrd,
   output logic [15:0] core_xaddr,
   output logic [7:0]  core_xdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      core_xwr = 1'b0;
      core_xrd = 1'b0;
      core_xaddr = 16'h0000;
      core_xdata = 8'h00;
   end
   ////////////////////////////////////////
   // one-cycle access; lines are scrambled afterwards so stale values never pass
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      core_xwr <= wr;
      core_xrd <= !wr;
      core_xaddr <= a;
      core_xdata <= d;
      @(posedge ref_clk);
      core_xwr <= 1'b0;
      core_xrd <= 1'b0;
      core_xaddr <= ~a;
      core_xdata <= ~d;
   endtask
endmodule

// ===== test/flash_program_erase_control_tb.sv
// self-checking bench for the flash program and erase sequencer
module flash_program_erase_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [15:0] code_rd_addr = 16'h0000;
   logic [31:0] rd;
   logic        err;
   wire  [31:0] prdata;
   wire  [15:0] xa;
   wire  [15:0] external_data_ram_addr;
   wire  [7:0]  xd;
   wire  [7:0]  external_data_ram_wdata;
   wire  [7:0]  code_rd_data;
   wire         pready, pslverr, xwr, xrd, core_stall, external_data_ram_we, external_data_ram_re;
   wire         frts, flash_lockout;
   int          num_errors = 0;
   int          comparisons = 0;
   always #25 ref_clk = ~ref_clk;
   fpec_top #(.ERASE_CYCLES(19'h0_0258)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_xwr(xwr),
      .core_xrd(xrd), .core_xaddr(xa), .core_xdata(xd), .core_stall(core_stall),
      .external_data_ram_we(external_data_ram_we), .external_data_ram_re(external_data_ram_re), .external_data_ram_addr(external_data_ram_addr),
      .external_data_ram_wdata(external_data_ram_wdata), .code_rd_addr(code_rd_addr), .code_rd_data(code_rd_data),
      .flash_read_timing_select(frts), .flash_lockout(flash_lockout));
   fpec_core_model core (.ref_clk(ref_clk), .core_xwr(xwr), .core_xrd(xrd),
      .core_xaddr(xa), .core_xdata(xd));
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic hang();
      check(32'h0000_0000, 32'h0000_0001);
      end_sim();
   endtask
   task automatic rst_dut();
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic keys();
      apb(1'b1, 12'h000, 32'h0000_00A5);
      apb(1'b1, 12'h000, 32'h0000_00F1);
   endtask
   // store, then count stall cycles from the cycle after the store edge
   task automatic op(input logic [15:0] a, input logic [7:0] d, input int cyc);
      int n = 0;
      core.access(1'b1, a, d);
      #1;
      while (core_stall === 1'b1 && n < 20000) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n >= 20000) hang();
      check(32'(n), 32'(cyc));
   endtask
   task automatic peek(input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      code_rd_addr <= a;
      @(posedge ref_clk);
      #1;
      check({24'h00_0000, code_rd_data}, {24'h00_0000, exp});
   endtask
   ////////////////////////////////////////
   task automatic t_apb();
      apb(1'b1, 12'h00C, 32'h0000_0001);
      #1;
      check({31'h0, frts}, 32'h0000_0001);
      check({30'h0, pready, err}, 32'h0000_0002);
      apb(1'b0, 12'h020, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      check(rd, 32'h0000_0000);
   endtask
   task automatic t_erase();
      keys();
      apb(1'b1, 12'h004, 32'h0000_0002);
      apb(1'b1, 12'h004, 32'h0000_0003);
      op(16'h0200, 8'h00, 600);
      apb(1'b1, 12'h004, 32'h0000_0002);
      apb(1'b1, 12'h004, 32'h0000_0000);
      peek(16'h0200, 8'hFF);
      peek(16'h0301, 8'hFF);
      peek(16'h03FF, 8'hFF);
      apb(1'b0, 12'h010, 32'h0000_0000);
      check(rd & 32'h0000_0003, 32'h0000_0000);
   endtask
   task automatic t_byte();
      apb(1'b1, 12'h008, 32'h0000_0000);
      apb(1'b1, 12'h004, 32'h0000_0001);
      keys();
      op(16'h0203, 8'h5A, 1100);
      peek(16'h0203, 8'h5A);
      keys();
      op(16'h0203, 8'hF0, 1100);
      peek(16'h0203, 8'h50);
      op(16'h0205, 8'h00, 0);
      check({31'h0, flash_lockout}, 32'h0000_0001);
      keys();
      op(16'h0205, 8'h00, 0);
      rst_dut();
   endtask
   task automatic t_key_fail();
      logic [7:0] codes [2] = '{8'h5A, 8'hF1};
      foreach (codes[i]) begin
         apb(1'b1, 12'h000, {24'h00_0000, codes[i]});
         #1;
         check({31'h0, flash_lockout}, 32'h0000_0001);
         rst_dut();
      end
   endtask
   task automatic t_block();
      apb(1'b1, 12'h004, 32'h0000_0001);
      apb(1'b1, 12'h008, 32'h0000_0001);
      apb(1'b1, 12'h000, 32'h0000_00A5);
      repeat (40) @(posedge ref_clk);
      apb(1'b1, 12'h000, 32'h0000_00F1);
      op(16'h0210, 8'h12, 0);
      apb(1'b0, 12'h010, 32'h0000_0000);
      check(rd & 32'h0000_000F, 32'h0000_0008);
      keys();
      op(16'h0211, 8'h34, 1100);
      peek(16'h0210, 8'h12);
      peek(16'h0211, 8'h34);
      keys();
      op(16'h0212, 8'hFF, 0);
      keys();
      op(16'h0213, 8'h0F, 1100);
      peek(16'h0212, 8'hFF);
      peek(16'h0213, 8'h0F);
   endtask
   task automatic t_external_data_ram();
      for (int c = 0; c < 3; c += 2) begin
         apb(1'b1, 12'h004, 32'(c));
         op(16'h0300, 8'h77, 0);
         check({31'h0, external_data_ram_we}, 32'h0000_0001);
         check({24'h00_0000, external_data_ram_wdata}, 32'h0000_0077);
      end
      core.access(1'b0, 16'h0211, 8'h00);
      #1;
      check({31'h0, external_data_ram_re}, 32'h0000_0001);
      check({16'h0000, external_data_ram_addr}, 32'h0000_0211);
   endtask
   task automatic t_resv();
      apb(1'b1, 12'h004, 32'h0000_0001);
      keys();
      op(16'hFC00, 8'h00, 0);
      apb(1'b0, 12'h010, 32'h0000_0000);
      check(rd & 32'h0000_0003, 32'h0000_0000);
      check({31'h0, flash_lockout}, 32'h0000_0000);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      t_apb();
      t_erase();
      t_byte();
      t_key_fail();
      t_block();
      t_external_data_ram();
      t_resv();
      end_sim();
   end
endmodule
